//--- logic/isl_slave.sv
// Two-wire bus slave engine with software register ports
`timescale 1ns/100ps
module isl_slave import isl_pkg::*; (
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	isl_bus_if.dev bus,
	input wire logic [7:0] sw_wdata_in,
	input wire logic sw_ctrl_wr_in,
	input wire logic sw_addr_wr_in,
	input wire logic sw_buf_wr_in,
	input wire logic sw_buf_rd_in,
	input wire logic sw_irq_clr_in,
	input wire logic pin_dir_scl_in,
	input wire logic pin_dir_sda_in,
	output logic [7:0] ctrl_out,
	output logic [7:0] status_out,
	output logic [7:0] buf_out,
	output logic [7:0] addr_out,
	output logic irq_flag_out
);
	isl_sst_t state_r;
	isl_ph_t ph_r;
	logic [7:0] ctrl_r;
	logic [7:0] addr_r;
	logic [7:0] buf_r;
	logic [7:0] sr_r;
	logic [3:0] cnt_r;
	logic scl_meta_r, scl_sync_r, scl_prev_r;
	logic sda_meta_r, sda_sync_r, sda_prev_r;
	logic bf_r, ua_r, rw_r, s_r, p_r, da_r, irq_r;
	logic ack_r, tx_r, ua_pend_r, ten_done_r;
	logic scl_oe_r, sda_oe_r;

	wire [3:0] mode = ctrl_r[CTL_MODE_HI:0];
	wire en = ctrl_r[CTL_EN];
	wire bus_on = en & (is_slave(mode) | (mode == MODE_FWM));
	wire slv_on = en & is_slave(mode);
	wire ten = mode[MODE_TEN_POS];
	wire clock_release_bit = ctrl_r[CTL_CKP];
	wire ov = ctrl_r[CTL_OV];

	wire scl_rise = scl_sync_r & ~scl_prev_r;
	wire scl_fall = ~scl_sync_r & scl_prev_r;
	wire scl_hi = scl_sync_r & scl_prev_r;
	wire start_ev = bus_on & scl_hi & sda_prev_r & ~sda_sync_r;
	wire stop_ev = bus_on & scl_hi & ~sda_prev_r & sda_sync_r;

	wire in_rx = state_r == SS_RX;
	wire byte_end = in_rx & scl_fall & (cnt_r == BYTE_BITS);
	wire hi_match = sr_r[7:1] == addr_r[7:1];
	wire hdr10 = sr_r[7:3] == HDR10;
	wire rd_req = sr_r[0];
	// A read header in 10-bit mode only counts once a low address byte has been received after a high-byte match
	wire ok_a1 = ten ? (hi_match & hdr10 & (~rd_req | ten_done_r)) : hi_match;
	wire hit = (ph_r == PH_DATA) | ((ph_r == PH_ADDR2) & (sr_r == addr_r)) |
		((ph_r == PH_ADDR1) & ok_a1);
	wire room = ~bf_r & ~ov;
	wire take = byte_end & hit;
	wire load = take & room;
	wire to_tx = (ph_r == PH_ADDR1) & rd_req;
	wire ninth_fall = (state_r == SS_ACK) & scl_fall;
	wire nack_end = (state_r == SS_MACK) & scl_rise & sda_sync_r;
	wire tx_fall = (state_r == SS_TX) & scl_fall;
	wire ckp_clr = ninth_fall & tx_r;
	wire ua_set = ninth_fall & ua_pend_r;
	wire irq_set = ninth_fall | nack_end | (has_sp(mode) & (start_ev | stop_ev));
	// Event terms let the stretch start before the master can release the clock
	wire stretch = ~clock_release_bit | ua_r | ckp_clr | ua_set;
	wire sda_drv = ((state_r == SS_ACK) & ack_r) | ((state_r == SS_TX) & ~sr_r[7]);

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			{scl_meta_r, scl_sync_r, scl_prev_r} <= 3'h7;
			{sda_meta_r, sda_sync_r, sda_prev_r} <= 3'h7;
		end else begin
			{scl_meta_r, scl_sync_r, scl_prev_r} <= {bus.scl, scl_meta_r, scl_sync_r};
			{sda_meta_r, sda_sync_r, sda_prev_r} <= {bus.sda, sda_meta_r, sda_sync_r};
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_r <= SS_IDLE;
			ph_r <= PH_ADDR1;
			cnt_r <= 4'h0;
			ack_r <= 1'h0;
			tx_r <= 1'h0;
			ua_pend_r <= 1'h0;
			ten_done_r <= 1'h0;
		end else if (!slv_on || stop_ev) begin
			state_r <= SS_IDLE;
			ph_r <= PH_ADDR1;
			ten_done_r <= 1'h0;
			tx_r <= 1'h0;
			ack_r <= 1'h0;
		end else if (start_ev) begin
			state_r <= SS_RX;
			ph_r <= PH_ADDR1;
			cnt_r <= 4'h0;
			tx_r <= 1'h0;
			ack_r <= 1'h0;
		end else begin
			unique case (state_r)
				SS_IDLE: begin
					cnt_r <= 4'h0;
				end
				SS_RX: begin
					if (scl_rise) begin
						cnt_r <= cnt_r + 4'h1;
					end else if (byte_end) begin
						state_r <= hit ? SS_ACK : SS_IDLE;
						ack_r <= hit & room;
						tx_r <= to_tx;
						ua_pend_r <= ten & (ph_r != PH_DATA) & ~to_tx;
						if (ph_r == PH_ADDR1) begin
							ph_r <= (ten & ~rd_req) ? PH_ADDR2 : PH_DATA;
						end else if (ph_r == PH_ADDR2) begin
							ph_r <= PH_DATA;
							ten_done_r <= 1'h1;
						end
					end
				end
				SS_ACK: begin
					if (scl_fall) begin
						state_r <= tx_r ? SS_TX : SS_RX;
						cnt_r <= 4'h0;
						ack_r <= 1'h0;
					end
				end
				SS_TX: begin
					if (scl_fall) begin
						state_r <= (cnt_r == LAST_BIT) ? SS_MACK : SS_TX;
						cnt_r <= cnt_r + 4'h1;
					end
				end
				SS_MACK: begin
					if (scl_rise) begin
						state_r <= sda_sync_r ? SS_IDLE : SS_ACK;
						tx_r <= ~sda_sync_r;
						ua_pend_r <= 1'h0;
					end
				end
				default: begin
					state_r <= SS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sr_r <= BYTE_RST;
		end else if (in_rx && scl_rise) begin
			sr_r <= {sr_r[6:0], sda_sync_r};
		end else if (tx_fall) begin
			sr_r <= {sr_r[6:0], 1'h0};
		end else if (sw_buf_wr_in) begin
			sr_r <= sw_wdata_in;
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			buf_r <= BYTE_RST;
			addr_r <= ADDR_RST;
		end else begin
			if (load) begin
				buf_r <= sr_r;
			end else if (sw_buf_wr_in) begin
				buf_r <= sw_wdata_in;
			end
			if (sw_addr_wr_in) begin
				addr_r <= sw_wdata_in;
			end
		end
	end

	// Hardware updates win over a software write in the same cycle
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctrl_r <= CTRL_RST;
		end else begin
			if (sw_ctrl_wr_in) begin
				ctrl_r <= sw_wdata_in;
			end
			if (take && bf_r) begin
				ctrl_r[CTL_OV] <= 1'h1;
			end
			if (ckp_clr) begin
				ctrl_r[CTL_CKP] <= 1'h0;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			{bf_r, ua_r, rw_r, da_r, irq_r} <= 5'h00;
		end else begin
			bf_r <= load | (bf_r & ~sw_buf_rd_in & ~nack_end);
			ua_r <= ua_set | (ua_r & ~sw_addr_wr_in & ~nack_end);
			irq_r <= irq_set | (irq_r & ~sw_irq_clr_in);
			if (take && (ph_r == PH_ADDR1)) begin
				rw_r <= rd_req;
			end else if (nack_end) begin
				rw_r <= 1'h0;
			end
			if (take) begin
				da_r <= ph_r == PH_DATA;
			end else if (nack_end) begin
				da_r <= 1'h0;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			{s_r, p_r} <= 2'h0;
		end else if (!en) begin
			{s_r, p_r} <= 2'h0;
		end else if (start_ev) begin
			{s_r, p_r} <= 2'h2;
		end else if (stop_ev) begin
			{s_r, p_r} <= 2'h1;
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			scl_oe_r <= 1'h0;
			sda_oe_r <= 1'h0;
		end else begin
			scl_oe_r <= slv_on & pin_dir_scl_in & stretch;
			sda_oe_r <= bus_on & pin_dir_sda_in & sda_drv;
		end
	end

	assign bus.scl_s_o = 1'h0;
	assign bus.sda_s_o = 1'h0;
	assign bus.scl_s_oe = scl_oe_r;
	assign bus.sda_s_oe = sda_oe_r;
	assign ctrl_out = ctrl_r;
	assign status_out = {2'h0, da_r, p_r, s_r, rw_r, ua_r, bf_r};
	assign buf_out = buf_r;
	assign addr_out = addr_r;
	assign irq_flag_out = irq_r;
endmodule : isl_slave

//--- logic/isl_pkg.sv
// Shared constants, encodings and decode functions for the two-wire slave engine and its master
package isl_pkg;
	// System clock and link timing
	localparam int SYS_CLK_NS = 100;
	localparam int LINK_HALF_NS = 400;
	localparam logic [2:0] HALF_CYC = 3'((LINK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
	localparam logic [2:0] HALF_LAST = HALF_CYC - 3'h1;

	// Mode select codes
	localparam logic [3:0] MODE_SLV7 = 4'h6;
	localparam logic [3:0] MODE_SLV10 = 4'h7;
	localparam logic [3:0] MODE_FWM = 4'hB;
	localparam logic [3:0] MODE_SLV7_SP = 4'hE;
	localparam logic [3:0] MODE_SLV10_SP = 4'hF;
	localparam int MODE_TEN_POS = 0;

	// Serial control register fields
	localparam int CTL_OV = 6;
	localparam int CTL_EN = 5;
	localparam int CTL_CKP = 4;
	localparam int CTL_MODE_HI = 3;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] ADDR_RST = 8'h00;
	localparam logic [7:0] BYTE_RST = 8'h00;

	// Byte framing
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] ACK_IDX = 4'h8;
	localparam logic [4:0] HDR10 = 5'h1E;

	typedef enum logic [4:0] {
		SS_IDLE = 5'h01,
		SS_RX = 5'h02,
		SS_ACK = 5'h04,
		SS_TX = 5'h08,
		SS_MACK = 5'h10
	} isl_sst_t;

	typedef enum logic [2:0] {
		PH_ADDR1 = 3'h1,
		PH_ADDR2 = 3'h2,
		PH_DATA = 3'h4
	} isl_ph_t;

	typedef enum logic [7:0] {
		MS_IDLE = 8'h01,
		MS_RS1 = 8'h02,
		MS_RS2 = 8'h04,
		MS_RS3 = 8'h08,
		MS_LOW = 8'h10,
		MS_HIGH = 8'h20,
		MS_SP1 = 8'h40,
		MS_SP2 = 8'h80
	} isl_mst_t;

	typedef enum logic [1:0] {
		CMD_START = 2'h0,
		CMD_WRITE = 2'h1,
		CMD_READ = 2'h2,
		CMD_STOP = 2'h3
	} isl_cmd_t;

	function automatic logic is_slave(input logic [3:0] m);
		return (m == MODE_SLV7) | (m == MODE_SLV10) | (m == MODE_SLV7_SP) | (m == MODE_SLV10_SP);
	endfunction : is_slave

	function automatic logic has_sp(input logic [3:0] m);
		return (m == MODE_SLV7_SP) | (m == MODE_SLV10_SP) | (m == MODE_FWM);
	endfunction : has_sp
endpackage : isl_pkg

//--- logic/isl_bus_if.sv
// Open-drain two-wire bus joining the slave engine and the bus master
`timescale 1ns/100ps
interface isl_bus_if;
	logic scl_m_o;
	logic scl_m_oe;
	logic sda_m_o;
	logic sda_m_oe;
	logic scl_s_o;
	logic scl_s_oe;
	logic sda_s_o;
	logic sda_s_oe;
	logic scl;
	logic sda;

	// Wired-AND with external pull-up
	assign scl = ~((scl_m_oe & ~scl_m_o) | (scl_s_oe & ~scl_s_o));
	assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

	modport dev (input scl, input sda, output scl_s_o, output scl_s_oe,
		output sda_s_o, output sda_s_oe);
	modport mst (input scl, input sda, output scl_m_o, output scl_m_oe,
		output sda_m_o, output sda_m_oe);
endinterface : isl_bus_if

//--- logic/isl_master.sv
// Two-wire bus master end with a command port and clock-stretch awareness
`timescale 1ns/100ps
module isl_master import isl_pkg::*; (
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	isl_bus_if.mst bus,
	input wire logic cmd_valid_in,
	output logic cmd_ready_out,
	input wire isl_cmd_t cmd_kind_in,
	input wire logic [7:0] cmd_data_in,
	input wire logic cmd_ack_in,
	output logic rsp_valid_out,
	output logic [7:0] rsp_data_out,
	output logic rsp_nack_out
);
	isl_mst_t state_r;
	logic [2:0] tmr_r;
	logic [3:0] idx_r;
	logic [7:0] txd_r;
	logic [7:0] rxd_r;
	logic rd_r, ack_r, ready_r, rsp_valid_r, rsp_nack_r;
	logic [7:0] rsp_data_r;
	logic scl_oe_r, sda_oe_r;
	logic scl_meta_r, scl_sync_r, sda_meta_r, sda_sync_r;

	wire half_done = tmr_r == HALF_LAST;
	wire is_ack_bit = idx_r == ACK_IDX;
	wire bit_out = is_ack_bit ? (rd_r ? ~ack_r : 1'h1) : (rd_r ? 1'h1 : txd_r[7]);
	wire [2:0] tmr_inc = tmr_r + 3'h1;

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			{scl_meta_r, scl_sync_r, sda_meta_r, sda_sync_r} <= 4'hF;
		end else begin
			{scl_meta_r, scl_sync_r} <= {bus.scl, scl_meta_r};
			{sda_meta_r, sda_sync_r} <= {bus.sda, sda_meta_r};
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_r <= MS_IDLE;
			tmr_r <= 3'h0;
			idx_r <= 4'h0;
			txd_r <= BYTE_RST;
			rxd_r <= BYTE_RST;
			{rd_r, ack_r, rsp_valid_r, rsp_nack_r, scl_oe_r, sda_oe_r} <= 6'h00;
			ready_r <= 1'h1;
			rsp_data_r <= BYTE_RST;
		end else begin
			rsp_valid_r <= 1'h0;
			tmr_r <= half_done ? 3'h0 : tmr_inc;
			unique case (state_r)
				MS_IDLE: begin
					tmr_r <= 3'h0;
					if (cmd_valid_in && ready_r) begin
						ready_r <= 1'h0;
						idx_r <= 4'h0;
						txd_r <= cmd_data_in;
						rd_r <= cmd_kind_in == CMD_READ;
						ack_r <= cmd_ack_in;
						unique case (cmd_kind_in)
							CMD_START: state_r <= MS_RS1;
							CMD_WRITE: state_r <= MS_LOW;
							CMD_READ: state_r <= MS_LOW;
							CMD_STOP: state_r <= MS_SP1;
						endcase
					end
				end
				MS_RS1: begin
					sda_oe_r <= 1'h0;
					if (half_done) begin
						scl_oe_r <= 1'h0;
						state_r <= MS_RS2;
					end
				end
				MS_RS2: begin
					// Clock may be stretched: count high time only once seen high
					if (!scl_sync_r) begin
						tmr_r <= 3'h0;
					end else if (half_done) begin
						sda_oe_r <= 1'h1;
						state_r <= MS_RS3;
					end
				end
				MS_RS3: begin
					if (half_done) begin
						scl_oe_r <= 1'h1;
						ready_r <= 1'h1;
						state_r <= MS_IDLE;
					end
				end
				MS_LOW: begin
					sda_oe_r <= ~bit_out;
					if (half_done) begin
						scl_oe_r <= 1'h0;
						state_r <= MS_HIGH;
					end
				end
				MS_HIGH: begin
					if (!scl_sync_r) begin
						tmr_r <= 3'h0;
					end else if (half_done) begin
						scl_oe_r <= 1'h1;
						rxd_r <= {rxd_r[6:0], sda_sync_r};
						txd_r <= {txd_r[6:0], 1'h0};
						idx_r <= idx_r + 4'h1;
						state_r <= is_ack_bit ? MS_IDLE : MS_LOW;
						if (is_ack_bit) begin
							ready_r <= 1'h1;
							rsp_valid_r <= 1'h1;
							rsp_data_r <= rxd_r;
							rsp_nack_r <= sda_sync_r;
						end
					end
				end
				MS_SP1: begin
					sda_oe_r <= 1'h1;
					if (half_done) begin
						scl_oe_r <= 1'h0;
						state_r <= MS_SP2;
					end
				end
				MS_SP2: begin
					if (!scl_sync_r) begin
						tmr_r <= 3'h0;
					end else if (half_done) begin
						sda_oe_r <= 1'h0;
						ready_r <= 1'h1;
						state_r <= MS_IDLE;
					end
				end
				default: begin
					state_r <= MS_IDLE;
				end
			endcase
		end
	end

	assign bus.scl_m_o = 1'h0;
	assign bus.sda_m_o = 1'h0;
	assign bus.scl_m_oe = scl_oe_r;
	assign bus.sda_m_oe = sda_oe_r;
	assign cmd_ready_out = ready_r;
	assign rsp_valid_out = rsp_valid_r;
	assign rsp_data_out = rsp_data_r;
	assign rsp_nack_out = rsp_nack_r;
endmodule : isl_master

//--- tb/isl_bus_chk.sv
// Protocol checker on the two-wire bus between slave engine and master
`timescale 1ns/100ps
module isl_bus_chk (
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic scl_m_o,
	input wire logic scl_m_oe,
	input wire logic sda_m_o,
	input wire logic sda_m_oe,
	input wire logic scl_s_o,
	input wire logic scl_s_oe,
	input wire logic sda_s_o,
	input wire logic sda_s_oe,
	input wire logic scl,
	input wire logic sda
);
	default clocking @(posedge clk_sys_in);
	endclocking
	default disable iff (!arst_n_in);

	od_value_a: assert property (!scl_m_o && !sda_m_o && !scl_s_o && !sda_s_o)
		else $error("open-drain output value not low");
	rst_free_a: assert property (disable iff (1'b0)
		!arst_n_in |-> !scl_s_oe && !sda_s_oe && !scl_m_oe && !sda_m_oe)
		else $error("line driven during reset");
	idle_rst_a: assert property ($rose(arst_n_in) |-> scl && sda)
		else $error("bus not idle after reset");
	sda_hold_a: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
		else $error("slave changed data while clock high");
	sda_drive_a: assert property ($rose(sda_s_oe) |-> !$past(scl))
		else $error("slave began driving data with clock high");
	sda_free_a: assert property ($rose(sda_s_oe) |-> ##[1:200] !sda_s_oe)
		else $error("slave held data line too long");
	stretch_low_a: assert property ($rose(scl_s_oe) |-> !$past(scl))
		else $error("slave cut a clock high phase");
	stretch_ack_a: assert property ($rose(scl_s_oe) |-> $past(sda_s_oe, 3))
		else $error("stretch without a preceding acknowledge");
	mst_wait_a: assert property ($rose(scl_m_oe) |-> $past(scl) && $past(scl, 3))
		else $error("master pulled clock before a full high phase");
endmodule : isl_bus_chk

//--- tb/tb_top.sv
// Self-checking bench: slave engine and master joined on one bus
`timescale 1ns/100ps
module tb_top import isl_pkg::*;;
	logic clk_sys_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [4:0] stb = 5'h00;
	logic dir_sda = 1'b1;
	logic cmd_valid = 1'b0;
	isl_cmd_t cmd_kind = CMD_START;
	logic [7:0] cmd_data = 8'h00;
	logic cmd_ack = 1'b0;
	logic cmd_ready, rsp_valid, rsp_nack, irq;
	logic [7:0] ctrl, stat, bufv, addr, rsp_data;
	int n_fail = 0;
	int checks_done = 0;
	int n_rsp = 0;
	// Mode, address byte, expected no-ack
	logic [15:0] rows [6] = '{16'h6A00, 16'hEA00, 16'h6A41, 16'hBA01, 16'h7A01, 16'hFA01};

	isl_bus_if bus ();
	always #50 clk_sys_in = ~clk_sys_in;

	// Response pulses counted mid-cycle, where they are settled
	always @(negedge clk_sys_in) begin
		if (rsp_valid === 1'b1) begin
			n_rsp++;
		end
	end

	isl_slave i_isl_slave (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .bus(bus.dev),
		.sw_wdata_in(wdata), .sw_ctrl_wr_in(stb[4]), .sw_addr_wr_in(stb[3]),
		.sw_buf_wr_in(stb[2]), .sw_buf_rd_in(stb[1]), .sw_irq_clr_in(stb[0]),
		.pin_dir_scl_in(1'b1), .pin_dir_sda_in(dir_sda), .ctrl_out(ctrl),
		.status_out(stat), .buf_out(bufv), .addr_out(addr), .irq_flag_out(irq));
	isl_master i_isl_master (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .bus(bus.mst),
		.cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .cmd_kind_in(cmd_kind),
		.cmd_data_in(cmd_data), .cmd_ack_in(cmd_ack), .rsp_valid_out(rsp_valid),
		.rsp_data_out(rsp_data), .rsp_nack_out(rsp_nack));
	isl_bus_chk i_isl_bus_chk (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
		.scl_m_o(bus.scl_m_o), .scl_m_oe(bus.scl_m_oe), .sda_m_o(bus.sda_m_o),
		.sda_m_oe(bus.sda_m_oe), .scl_s_o(bus.scl_s_o), .scl_s_oe(bus.scl_s_oe),
		.sda_s_o(bus.sda_s_o), .sda_s_oe(bus.sda_s_oe), .scl(bus.scl), .sda(bus.sda));

	task final_report();
		$display("Checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report

	task chk(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	// Strobes: ctrl, addr, buf write, buf read, irq clear
	task sw(input logic [4:0] s, input logic [7:0] d);
		stb <= s;
		wdata <= d;
		@(posedge clk_sys_in);
		stb <= 5'h00;
		@(posedge clk_sys_in);
	endtask : sw

	// Slow link: allow the slave flags a few cycles to settle
	task cmd(input isl_cmd_t k, input logic [7:0] d, input logic a);
		int n;
		n = 0;
		cmd_kind <= k;
		cmd_data <= d;
		cmd_ack <= a;
		cmd_valid <= 1'b1;
		do @(posedge clk_sys_in); while (cmd_ready !== 1'b1 && ++n < 3000);
		cmd_valid <= 1'b0;
		do @(posedge clk_sys_in); while (cmd_ready !== 1'b1 && ++n < 3000);
		// A command that never completes is a failure, not a pass
		if (n >= 3000) begin
			n_fail++;
		end
		repeat (10) @(posedge clk_sys_in);
	endtask : cmd

	task wr(input logic [7:0] d, input logic [7:0] nack);
		int r0;
		r0 = n_rsp;
		cmd(CMD_WRITE, d, 1'b0);
		chk(8'(n_rsp - r0), 8'h01);
		chk({7'h00, rsp_nack}, nack);
	endtask : wr

	initial begin
		#2000000;
		n_fail++;
		final_report();
	end

	initial begin
		repeat (12) @(posedge clk_sys_in);
		arst_n_in <= 1'b1;
		@(posedge clk_sys_in);
		chk(ctrl | stat | bufv | addr, 8'h00);
		chk({5'h00, bus.scl, bus.sda, irq}, 8'h06);
		sw(5'h08, 8'hA0);
		foreach (rows[i]) begin
			sw(5'h10, {4'h3, rows[i][15:12]});
			chk(ctrl, {4'h3, rows[i][15:12]});
			cmd(CMD_START, 8'h00, 1'b0);
			wr(rows[i][11:4], {7'h00, rows[i][0]});
			if (rows[i][0] == 1'b0) begin
				chk(bufv, rows[i][11:4]);
				chk({irq, stat[2:0]}, 8'h09);
			end
			sw(5'h13, {4'h3, rows[i][15:12]});
			cmd(CMD_STOP, 8'h00, 1'b0);
			chk({irq, stat[4:3]}, {5'h00, rows[i][15], 2'h2});
		end
		sw(5'h10, 8'h36);
		// Overflow: unread buffer, then stale overflow flag
		cmd(CMD_START, 8'h00, 1'b0);
		wr(8'hA0, 8'h00);
		sw(5'h13, 8'h36);
		wr(8'h5A, 8'h00);
		chk(bufv, 8'h5A);
		sw(5'h01, 8'h00);
		wr(8'h33, 8'h01);
		chk(bufv, 8'h5A);
		chk({irq, stat[0], ctrl[6]}, 8'h07);
		sw(5'h03, 8'h00);
		chk({stat[0], ctrl[6]}, 8'h01);
		wr(8'h44, 8'h01);
		chk(bufv, 8'h5A);
		sw(5'h11, 8'h36);
		wr(8'h44, 8'h00);
		chk(bufv, 8'h44);
		sw(5'h13, 8'h36);
		cmd(CMD_STOP, 8'h00, 1'b0);
		// Data pin set as output: slave must stay off the line
		dir_sda <= 1'b0;
		cmd(CMD_START, 8'h00, 1'b0);
		wr(8'hA0, 8'h01);
		dir_sda <= 1'b1;
		sw(5'h13, 8'h36);
		cmd(CMD_STOP, 8'h00, 1'b0);
		// Read, master declines the byte
		cmd(CMD_START, 8'h00, 1'b0);
		wr(8'hA1, 8'h00);
		chk({bus.scl_s_oe, stat[2:0]}, 8'h0D);
		sw(5'h04, 8'hC3);
		sw(5'h13, 8'h36);
		cmd(CMD_READ, 8'h00, 1'b0);
		chk(rsp_data, 8'hC3);
		chk({irq, stat[2:0]}, 8'h08);
		cmd(CMD_STOP, 8'h00, 1'b0);
		// Ten-bit write of both address bytes, then repeated start read
		sw(5'h10, 8'h37);
		sw(5'h08, 8'hF2);
		cmd(CMD_START, 8'h00, 1'b0);
		wr(8'hF2, 8'h00);
		chk({irq, stat[2:0]}, 8'h0B);
		sw(5'h08, 8'h34);
		chk({7'h00, stat[1]}, 8'h00);
		sw(5'h13, 8'h37);
		wr(8'h34, 8'h00);
		chk({irq, stat[2:0]}, 8'h0B);
		sw(5'h08, 8'hF2);
		sw(5'h13, 8'h37);
		cmd(CMD_START, 8'h00, 1'b0);
		wr(8'hF3, 8'h00);
		chk({irq, stat[2:0]}, 8'h0D);
		sw(5'h04, 8'h96);
		sw(5'h13, 8'h37);
		cmd(CMD_READ, 8'h00, 1'b0);
		chk(rsp_data, 8'h96);
		cmd(CMD_STOP, 8'h00, 1'b0);
		arst_n_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		arst_n_in <= 1'b1;
		@(posedge clk_sys_in);
		chk(ctrl | addr, 8'h00);
		final_report();
	end
endmodule : tb_top
